// File: rtl/rprs_pkg.sv
/*
  Shared constants for the reference picture warp resampler: field widths,
  fill and accuracy codes, picture types, fill levels and grid constants.
  Assumes nothing of its surroundings; imported by every design file.
*/
package rprs_pkg;

  // ----------------------------------------------------------------------
  // Widths and FIFO depth
  // ----------------------------------------------------------------------
  localparam int DIM_W = 11;   // Picture sizes up to 2047 pixels
  localparam int WP_W = 13;    // Warping parameters, -4095..+4095
  localparam int RV_W = 22;    // Resampling vectors in 1/32 pel
  localparam int NUM_W = 56;   // Numerators of the displacement sums
  localparam int POS_W = 20;   // Reference positions in 1/16 pel
  localparam int PIX_W = 8;
  localparam int ADDR_W = 22;
  localparam int FRAC_W = 4;   // Interpolation phase in 1/16 pel
  localparam int PLANE_W = 2;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] FILL_COLOR = 2'h0;
  localparam logic [1:0] FILL_BLACK = 2'h1;
  localparam logic [1:0] FILL_GRAY = 2'h2;
  localparam logic [1:0] FILL_CLIP = 2'h3;
  localparam logic [1:0] ACC_HALF = 2'h2;
  localparam logic [1:0] ACC_SIXTEENTH = 2'h3;
  localparam logic [2:0] PT_INTRA = 3'h0;
  localparam logic [2:0] PT_INTER = 3'h1;
  localparam logic [2:0] PT_B = 3'h2;
  localparam logic [2:0] PT_EP = 3'h3;
  localparam logic [2:0] PT_IPB = 3'h4;
  localparam logic [1:0] PL_Y = 2'h0;
  localparam logic [1:0] PL_CB = 2'h1;
  localparam logic [1:0] PL_CR = 2'h2;

  // ----------------------------------------------------------------------
  // Levels and grid constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] LEVEL_BLACK_Y = 8'h10;
  localparam logic [7:0] LEVEL_MID = 8'h80;
  localparam logic [10:0] MB_ROUND = 11'h00F;  // Macroblock size less one
  localparam int U_SCALE_SH = 4;     // Corner displacements times 16
  localparam int HV_SH = 2;          // Denominator 4HV from half-unit indices
  localparam int QSH_SIXTEENTH = 1;  // 1/32 grid to 1/16 steps
  localparam int QSH_HALF = 4;       // 1/32 grid to 1/2 steps
  localparam int BLEND_SH = 8;       // Two 1/16 weights multiplied
  localparam logic [16:0] BLEND_RND = 17'h0_0080;
  localparam logic [4:0] W_ONE = 5'h10;

endpackage

// File: rtl/rprs_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides, parameterised in
  width and depth. Assumes one clock and an asynchronous active-low reset;
  depth must be a power of two.
*/
`timescale 1ns/1ns
module rprs_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import rprs_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rprs_fifo_regs_t;

  rprs_fifo_regs_t q;
  rprs_fifo_regs_t d;
  logic push;
  logic pop;

  // ----------------------------------------------------------------------
  // Handshakes: full and empty come straight from the count
  // ----------------------------------------------------------------------
  assign in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// File: rtl/rprs_resampler.sv
/*
  Reference picture warp resampler. Builds the warped prediction reference
  of the current picture from the previous decoded reference, pixel by
  pixel, and streams it out through an 8-word FIFO.
  Assumes: the header parser holds the picture inputs stable from start
  until done; the frame memory answers reads in order, on the same clock.
*/
// Behaviour
// - Size change without resampling flag: zero warp, clip fill, 1/16 pel
// - B picture resamples only the previous anchor, never the next one
// - That previous anchor is taken as decoded, before any resampling
// - Improved PB frame: one warp set, one resampled reference for both parts
// - With reference selection, resample only if all headers pick one picture
// - Four corner vectors map current corners onto reference corners
// - Interior displacement is bilinear weighting of corners by x/H, y/V
// - Sizes are used as signalled, even when not multiples of 16
// - Padding up to whole macroblocks uses the same fill mode
// - Resampling vectors: corner, top difference, left difference, cross term
// - Origin top left, pixel centres at index plus one half
// - Positions and phases are taken relative to the top-left pixel centre
// - Each output pixel is a bilinear blend of four reference samples, except outside pixels in the non-clip modes
// - Size components: zero, width difference, height difference, zero
// - Fill code 11 clips coordinates to the border, replicating edges
// - Accuracy code 11 quantises to 1/16 pel, code 10 to half pel
`timescale 1ns/1ns
module rprs_resampler (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [2:0] pic_type,
  input wire logic ext_type_present,
  input wire logic resample_flag,
  input wire logic [rprs_pkg::DIM_W-1:0] cur_h,
  input wire logic [rprs_pkg::DIM_W-1:0] cur_v,
  input wire logic [rprs_pkg::DIM_W-1:0] prev_h,
  input wire logic [rprs_pkg::DIM_W-1:0] prev_v,
  input wire logic [rprs_pkg::DIM_W-1:0] ref_h,
  input wire logic [rprs_pkg::DIM_W-1:0] ref_v,
  input wire logic [7:0][rprs_pkg::WP_W-1:0] warp_param,
  input wire logic [1:0] fill_mode,
  input wire logic [1:0] disp_accuracy,
  input wire logic [rprs_pkg::PIX_W-1:0] fill_y,
  input wire logic [rprs_pkg::PIX_W-1:0] fill_cb,
  input wire logic [rprs_pkg::PIX_W-1:0] fill_cr,
  input wire logic ref_select_on,
  input wire logic ref_select_same,
  input wire logic [rprs_pkg::ADDR_W-1:0] prev_anchor_base,
  input wire logic [rprs_pkg::ADDR_W-1:0] selected_ref_base,
  output logic ref_rd_en,
  output logic [rprs_pkg::ADDR_W-1:0] ref_rd_addr,
  input wire logic ref_rd_valid,
  input wire logic [rprs_pkg::PIX_W-1:0] ref_rd_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [rprs_pkg::PIX_W-1:0] out_pixel,
  output logic [rprs_pkg::PLANE_W-1:0] out_plane,
  output logic busy,
  output logic done,
  output logic resample_active,
  output logic refused
);
  import rprs_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_NUM, S_DIV, S_ADDR, S_FETCH, S_BLEND, S_DONE
  } rprs_state_t;

  typedef struct packed {
    rprs_state_t st;
    logic [PLANE_W-1:0] plane;
    logic [DIM_W-1:0] ci;
    logic [DIM_W-1:0] cj;
    logic [DIM_W-1:0] h;
    logic [DIM_W-1:0] v;
    logic [DIM_W-1:0] hr;
    logic [DIM_W-1:0] vr;
    logic [1:0] fill;
    logic [1:0] acc;
    logic [ADDR_W-1:0] base;
    logic [7:0][WP_W-1:0] wp;
    logic [7:0][RV_W-1:0] rv;
    logic signed [NUM_W-1:0] numx;
    logic signed [NUM_W-1:0] numy;
    logic signed [POS_W-1:0] posx;
    logic signed [POS_W-1:0] posy;
    logic outside;
    logic [3:0][ADDR_W-1:0] addr;
    logic [3:0][PIX_W-1:0] smp;
    logic [2:0] rd_cnt;
    logic [2:0] rcv_cnt;
    logic active;
    logic err;
    logic done;
  } rprs_regs_t;

  rprs_regs_t q;
  rprs_regs_t d;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Floor division; the divisor is always positive here
  function automatic logic signed [NUM_W-1:0] fdiv(
    input logic signed [NUM_W-1:0] n,
    input logic signed [NUM_W-1:0] dv
  );
    logic signed [NUM_W-1:0] r;
    r = n / dv;
    if ((n % dv != '0) && n[NUM_W-1]) begin
      r = r - NUM_W'(1);
    end
    return r;
  endfunction

  // Limit an integer coordinate to 0..lim-1
  function automatic logic [DIM_W-1:0] clampc(
    input logic signed [POS_W-1:0] c,
    input logic [DIM_W-1:0] lim
  );
    logic signed [POS_W-1:0] top;
    top = POS_W'(lim) - POS_W'(1);
    if (c[POS_W-1]) begin
      return '0;
    end else if (c > top) begin
      return DIM_W'(top);
    end
    return DIM_W'(c);
  endfunction

  // ----------------------------------------------------------------------
  // Invocation decisions at start
  // ----------------------------------------------------------------------
  logic inter_like;
  logic size_chg;
  logic implicit_go;
  logic explicit_go;
  logic rps_block;

  assign inter_like = (pic_type == PT_INTER) || (pic_type == PT_B) ||
                      (pic_type == PT_EP) || (pic_type == PT_IPB);
  // A selected reference decides the size comparison itself
  assign size_chg = ref_select_on ? (cur_h != ref_h) || (cur_v != ref_v)
                                  : (cur_h != prev_h) || (cur_v != prev_v);
  assign implicit_go = ext_type_present && !resample_flag &&
                       inter_like && size_chg;
  assign explicit_go = ext_type_present && resample_flag && inter_like;
  assign rps_block = ref_select_on && !ref_select_same;

  // ----------------------------------------------------------------------
  // Plane geometry, padded to whole macroblocks
  // ----------------------------------------------------------------------
  logic is_luma;
  logic [DIM_W-1:0] hpad;
  logic [DIM_W-1:0] vpad;
  logic [DIM_W-1:0] pw;
  logic [DIM_W-1:0] ph;
  logic [DIM_W-1:0] rw;
  logic [DIM_W-1:0] rh;
  logic [ADDR_W-1:0] area;
  logic [ADDR_W-1:0] pbase;

  assign is_luma = (q.plane == PL_Y);
  // Sizes stay as signalled; only the walk is padded
  assign hpad = (q.h + MB_ROUND) & ~MB_ROUND;
  assign vpad = (q.v + MB_ROUND) & ~MB_ROUND;
  assign pw = is_luma ? hpad : hpad >> 1;
  assign ph = is_luma ? vpad : vpad >> 1;
  assign rw = is_luma ? q.hr : q.hr >> 1;
  assign rh = is_luma ? q.vr : q.vr >> 1;
  assign area = ADDR_W'(q.hr) * ADDR_W'(q.vr);
  assign pbase = is_luma ? q.base :
                 (q.plane == PL_CB) ? q.base + area :
                 q.base + area + (area >> 2);

  // ----------------------------------------------------------------------
  // Displacement arithmetic, all exact integers
  // ----------------------------------------------------------------------
  logic signed [NUM_W-1:0] hs;
  logic signed [NUM_W-1:0] vs;
  logic signed [NUM_W-1:0] i2;
  logic signed [NUM_W-1:0] j2;
  logic signed [NUM_W-1:0] den;
  logic signed [NUM_W-1:0] vx32;
  logic signed [NUM_W-1:0] vy32;
  logic signed [NUM_W-1:0] rvs [8];
  int qsh;

  always_comb begin
    hs = NUM_W'(q.h);
    vs = NUM_W'(q.v);
    // Pixel centres in half units: luma 2i+1, chroma centre 4i+2
    i2 = is_luma ? NUM_W'({q.ci, 1'b1}) : NUM_W'({q.ci, 2'b10});
    j2 = is_luma ? NUM_W'({q.cj, 1'b1}) : NUM_W'({q.cj, 2'b10});
    for (int k = 0; k < 8; k++) begin
      rvs[k] = NUM_W'($signed(q.rv[k]));
    end
    // Quantise to the signalled displacement accuracy
    qsh = (q.acc == ACC_HALF) ? QSH_HALF : QSH_SIXTEENTH;
    den = (hs * vs) <<< (HV_SH + qsh);
    vx32 = fdiv(q.numx + (den >>> 1), den) <<< qsh;
    vy32 = fdiv(q.numy + (den >>> 1), den) <<< qsh;
  end

  // ----------------------------------------------------------------------
  // Sample coordinates and bilinear weights
  // ----------------------------------------------------------------------
  logic signed [POS_W-1:0] ix;
  logic signed [POS_W-1:0] iy;
  logic [FRAC_W-1:0] fx;
  logic [FRAC_W-1:0] fy;
  logic [DIM_W-1:0] x0;
  logic [DIM_W-1:0] x1;
  logic [DIM_W-1:0] y0;
  logic [DIM_W-1:0] y1;
  logic [16:0] blend;
  logic [PIX_W-1:0] fill_val;
  logic [4:0] wx1;
  logic [4:0] wy1;
  logic fifo_ready;

  assign ix = q.posx >>> FRAC_W;
  assign iy = q.posy >>> FRAC_W;
  assign fx = q.posx[FRAC_W-1:0];
  assign fy = q.posy[FRAC_W-1:0];
  // Independent clipping replicates border pixels
  assign x0 = clampc(ix, rw);
  assign x1 = clampc(ix + POS_W'(1), rw);
  assign y0 = clampc(iy, rh);
  assign y1 = clampc(iy + POS_W'(1), rh);
  assign wx1 = W_ONE - 5'(fx);
  assign wy1 = W_ONE - 5'(fy);

  // Four-tap blend of the neighbours with 1/16 phases
  assign blend = 17'(wx1) * 17'(wy1) * 17'(q.smp[0]) +
                 17'(fx) * 17'(wy1) * 17'(q.smp[1]) +
                 17'(wx1) * 17'(fy) * 17'(q.smp[2]) +
                 17'(fx) * 17'(fy) * 17'(q.smp[3]) + BLEND_RND;

  // Level for samples outside the reference in the non-clip modes
  always_comb begin
    unique case (q.fill)
      FILL_BLACK: fill_val = is_luma ? LEVEL_BLACK_Y : LEVEL_MID;
      FILL_GRAY: fill_val = LEVEL_MID;
      FILL_COLOR: fill_val = is_luma ? fill_y :
                             (q.plane == PL_CB) ? fill_cb : fill_cr;
      default: fill_val = LEVEL_MID;
    endcase
  end

  // ----------------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------------
  logic push;
  logic [PIX_W-1:0] push_val;
  logic last_col;
  logic last_row;

  assign last_col = (q.ci == pw - 1'b1);
  assign last_row = (q.cj == ph - 1'b1);
  assign push = (q.st == S_BLEND);
  assign push_val = q.outside ? fill_val : blend[BLEND_SH +: PIX_W];

  always_comb begin
    d = q;
    d.done = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        if (start) begin
          d.h = cur_h;
          d.v = cur_v;
          d.hr = ref_h;
          d.vr = ref_v;
          d.plane = PL_Y;
          d.ci = '0;
          d.cj = '0;
          d.err = rps_block;
          d.active = (implicit_go || explicit_go) && !rps_block;
          // One warp set per picture, shared by both PB parts
          d.wp = implicit_go ? '0 : warp_param;
          d.fill = implicit_go ? FILL_CLIP : fill_mode;
          d.acc = implicit_go ? ACC_SIXTEENTH : disp_accuracy;
          // Selected reference if selection is on, else decoded previous anchor; never the next one
          d.base = ref_select_on ? selected_ref_base
                                 : prev_anchor_base;
          d.st = d.active ? S_SETUP : S_DONE;
        end
      end
      S_SETUP: begin
        // Corner vectors with their size components
        // Order: x then y of r0, rx, ry, rxy in 1/32 pel
        for (int c = 0; c < 2; c++) begin
          d.rv[c] = RV_W'($signed(q.wp[c])) <<< U_SCALE_SH;
          d.rv[2 + c] = (RV_W'($signed(q.wp[2 + c])) +
                        (c == 0 ? RV_W'($signed({1'b0, q.hr}) -
                                  $signed({1'b0, q.h})) <<< 1 : '0))
                        <<< U_SCALE_SH;
          d.rv[4 + c] = (RV_W'($signed(q.wp[4 + c])) +
                        (c == 1 ? RV_W'($signed({1'b0, q.vr}) -
                                  $signed({1'b0, q.v})) <<< 1 : '0))
                        <<< U_SCALE_SH;
          d.rv[6 + c] = RV_W'($signed(q.wp[6 + c])) <<< U_SCALE_SH;
        end
        d.st = S_NUM;
      end
      S_NUM: begin
        // Bilinear weighting by x/H and y/V, scaled by 4HV
        d.numx = ((hs * vs * rvs[0]) <<< HV_SH) + ((i2 * vs * rvs[2]) <<< 1)
                 + ((j2 * hs * rvs[4]) <<< 1) + i2 * j2 * rvs[6];
        d.numy = ((hs * vs * rvs[1]) <<< HV_SH) + ((i2 * vs * rvs[3]) <<< 1)
                 + ((j2 * hs * rvs[5]) <<< 1) + i2 * j2 * rvs[7];
        d.st = S_DIV;
      end
      S_DIV: begin
        // Positions less one half, i.e. from the top-left centre
        // A 1/16 chroma step spans four 1/32 luma steps
        d.posx = is_luma ? POS_W'({q.ci, 4'h0}) + POS_W'(vx32 >>> 1)
                         : POS_W'({q.ci, 4'h0}) + POS_W'(vx32 >>> 2);
        d.posy = is_luma ? POS_W'({q.cj, 4'h0}) + POS_W'(vy32 >>> 1)
                         : POS_W'({q.cj, 4'h0}) + POS_W'(vy32 >>> 2);
        d.st = S_ADDR;
      end
      S_ADDR: begin
        d.outside = (q.fill != FILL_CLIP) &&
                    (ix < 0 || iy < 0 || ix > POS_W'(rw) - POS_W'(1) ||
                     iy > POS_W'(rh) - POS_W'(1));
        d.addr[0] = pbase + ADDR_W'(y0) * ADDR_W'(rw) + ADDR_W'(x0);
        d.addr[1] = pbase + ADDR_W'(y0) * ADDR_W'(rw) + ADDR_W'(x1);
        d.addr[2] = pbase + ADDR_W'(y1) * ADDR_W'(rw) + ADDR_W'(x0);
        d.addr[3] = pbase + ADDR_W'(y1) * ADDR_W'(rw) + ADDR_W'(x1);
        d.rd_cnt = '0;
        d.rcv_cnt = '0;
        d.st = d.outside ? S_BLEND : S_FETCH;
      end
      S_FETCH: begin
        if (!q.rd_cnt[2]) begin
          d.rd_cnt = q.rd_cnt + 3'h1;
        end
        if (ref_rd_valid) begin
          d.smp[q.rcv_cnt[1:0]] = ref_rd_data;
          d.rcv_cnt = q.rcv_cnt + 3'h1;
          if (q.rcv_cnt == 3'h3) begin
            d.st = S_BLEND;
          end
        end
      end
      S_BLEND: begin
        // Raster walk, luma then Cb then Cr
        if (fifo_ready) begin
          d.st = S_NUM;
          d.ci = last_col ? '0 : q.ci + 1'b1;
          if (last_col) begin
            d.cj = last_row ? '0 : q.cj + 1'b1;
          end
          if (last_col && last_row) begin
            d.plane = q.plane + 1'b1;
            if (q.plane == PL_CR) begin
              d.st = S_DONE;
            end
          end
        end
      end
      S_DONE: begin
        d.done = 1'b1;
        d.st = S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs; the FIFO stalls the walk when the consumer is slow
  // ----------------------------------------------------------------------
  assign ref_rd_en = (q.st == S_FETCH) && !q.rd_cnt[2];
  assign ref_rd_addr = q.addr[q.rd_cnt[1:0]];
  assign busy = (q.st != S_IDLE);
  assign done = q.done;
  assign resample_active = q.active;
  assign refused = q.err;

  rprs_fifo #(
    .W(PIX_W + PLANE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({q.plane, push_val}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_plane, out_pixel})
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_IMPLICIT_MODE:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == S_IDLE && start && implicit_go && !rps_block) |=>
      (q.fill == FILL_CLIP && q.acc == ACC_SIXTEENTH && q.wp == '0))
    else $error("implicit resampling not zero warp, clip, 1/16");
  AST_RPS_REFUSE:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == S_IDLE && start && rps_block) |=> ##1 (done && refused
      && !resample_active))
    else $error("mixed reference selection not refused");
  AST_PREV_ANCHOR:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == S_IDLE && start && !ref_select_on) |=>
      (q.base == $past(prev_anchor_base)))
    else $error("resampled picture is not the previous anchor");
  AST_WARP_HELD:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st != S_IDLE && $past(q.st) != S_IDLE) |-> $stable(q.wp))
    else $error("warp set changed inside one picture");
  AST_FOUR_READS:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == S_ADDR && !d.outside) |=> ref_rd_en [*4] ##1 !ref_rd_en)
    else $error("bilinear fetch is not four reads");
  AST_CLIP_INSIDE:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == S_ADDR && q.fill == FILL_CLIP) |=> !q.outside)
    else $error("clip mode used a fill level");
  AST_PLANE_ORDER:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st != S_IDLE && q.plane != $past(q.plane)) |->
      (q.plane == $past(q.plane) + 2'h1 && q.ci == '0 && q.cj == '0))
    else $error("planes not walked in raster order");
  AST_PHASE_GRID:
    assert property (@(posedge clk) disable iff (!rstn)
      (q.st == S_DIV && q.acc == ACC_HALF && is_luma) |=>
      (q.posx[2:0] == 3'h0 && q.posy[2:0] == 3'h0))
    else $error("half-pel accuracy produced finer phase");
  AST_DONE_PULSE:
    assert property (@(posedge clk) disable iff (!rstn)
      done |=> !done && q.st == S_IDLE)
    else $error("done longer than one cycle");

endmodule

// File: test/rprs_mem_model.sv
/*
  Frame memory model: answers reads in order, one sample per read.
  Assumes the resampler's clock and reset; slow adds a gap per answer.
*/
`timescale 1ns/1ns
module rprs_mem_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic ref_rd_en,
  input wire logic [rprs_pkg::ADDR_W-1:0] ref_rd_addr,
  output logic ref_rd_valid,
  output logic [rprs_pkg::PIX_W-1:0] ref_rd_data
);
  import rprs_pkg::*;
  logic [ADDR_W-1:0] pend[$];
  int gap;
  // Data wobbles between answers so a stale sample never looks right
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend.delete();
      gap = 0;
      ref_rd_valid <= 1'b0;
      ref_rd_data <= 8'h00;
    end else begin
      if (ref_rd_en === 1'b1)
        pend.push_back(ref_rd_addr);
      ref_rd_valid <= 1'b0;
      ref_rd_data <= ~ref_rd_data;
      if (pend.size() > 0 && gap > 0)
        gap--;
      else if (pend.size() > 0) begin
        ref_rd_valid <= 1'b1;
        ref_rd_data <= pend[0][7:0] ^ pend[0][15:8];
        pend.pop_front();
        gap = slow ? 3 : 0;
      end
    end
  end
endmodule

// File: test/test_rprs_resampler.sv
/*
  Testbench of the resampler: identity and one-pel shift warps, 12x12.
  Assumes the frame memory model; output stalls follow a fixed pattern.
*/
`timescale 1ns/1ns
module test_rprs_resampler;
  import rprs_pkg::*;
  logic clk = 0, rstn = 0, start = 0, ext = 0, flag = 0, slow = 0;
  logic sel_on = 0, sel_same = 0, out_ready = 0, rd_en, rd_valid;
  logic out_valid, busy, done, active, refused;
  logic [2:0] ptype = PT_INTER;
  logic [DIM_W-1:0] cur = 11'h00C, prev = 11'h00C;
  logic [1:0] fill = FILL_CLIP, acc = ACC_SIXTEENTH;
  logic [ADDR_W-1:0] pbase = '0, sbase = '0, rd_addr;
  logic [PIX_W-1:0] rd_data, pix;
  logic [PLANE_W-1:0] plane;
  // One pel shift to the right; implicit pictures must ignore it
  logic [7:0][WP_W-1:0] warp = {{7{13'h0000}}, 13'h0002};
  int n_mismatch = 0, n_compared = 0;
  always #10 clk = ~clk;
  rprs_resampler uut (.clk(clk), .rstn(rstn), .start(start),
    .pic_type(ptype), .ext_type_present(ext), .resample_flag(flag),
    .cur_h(cur), .cur_v(cur), .prev_h(prev), .prev_v(prev),
    .ref_h(cur), .ref_v(cur), .warp_param(warp), .fill_mode(fill),
    .disp_accuracy(acc), .fill_y(8'h55), .fill_cb(8'h66), .fill_cr(8'h77),
    .ref_select_on(sel_on), .ref_select_same(sel_same),
    .prev_anchor_base(pbase), .selected_ref_base(sbase),
    .ref_rd_en(rd_en), .ref_rd_addr(rd_addr), .ref_rd_valid(rd_valid),
    .ref_rd_data(rd_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_pixel(pix), .out_plane(plane), .busy(busy), .done(done),
    .resample_active(active), .refused(refused));
  rprs_mem_model mem (.clk(clk), .rstn(rstn), .slow(slow),
    .ref_rd_en(rd_en), .ref_rd_addr(rd_addr), .ref_rd_valid(rd_valid),
    .ref_rd_data(rd_data));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reference sample at a clipped row and column of one plane
  function automatic logic [7:0] smp(input int o, r, c, w,
    input logic [21:0] b);
    logic [21:0] a;
    a = b + 22'(o + (r < w ? r : w - 1) * w + (c < w ? c : w - 1));
    return a[7:0] ^ a[15:8];
  endfunction
  // Clip repeats edges, gray fills outside; a shift is half a chroma pel
  function automatic logic [7:0] want(input int n, input logic [21:0] b,
    input logic t, g);
    int s, w, k, o, x, y;
    s = n < 256 ? 16 : 8;
    w = n < 256 ? 12 : 6;
    k = n < 256 ? n : (n < 320 ? n - 256 : n - 320);
    o = n < 256 ? 0 : (n < 320 ? 144 : 180);
    x = k % s + ((t && n < 256) ? 1 : 0);
    y = k / s;
    if (g && (x >= w || y >= w))
      return 8'h80;
    if (t && n >= 256)
      return 8'((smp(o, y, x, w, b) + smp(o, y, x + 1, w, b) + 1) >> 1);
    return smp(o, y, x, w, b);
  endfunction
  // One picture; implicit cases get gray and half pel, which must be ignored
  task picture(input logic [2:0] t, input logic e, f, so, ss,
    input logic [10:0] pv, input logic [21:0] pb, sb, eb,
    input logic act, rf, sh, gr);
    int n, c;
    logic fin;
    @(posedge clk);
    {ptype, ext, flag, sel_on, sel_same} <= {t, e, f, so, ss};
    {prev, pbase, sbase} <= {pv, pb, sb};
    fill <= (f && !gr) ? FILL_CLIP : FILL_GRAY;
    acc <= (f && !gr) ? ACC_SIXTEENTH : ACC_HALF;
    slow <= ~slow;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    n = 0;
    c = 0;
    fin = 0;
    do begin
      @(negedge clk);
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        check("pixel", pix, want(n, eb, sh, gr));
        check("plane", plane, n < 256 ? PL_Y : (n < 320 ? PL_CB : PL_CR));
        n++;
      end
      check("busy", busy, !fin && done !== 1'b1);
      if (done === 1'b1)
        fin = 1;
      c++;
      @(posedge clk) out_ready <= c[2] | c[0];
    end while (c < 30000 && !(fin && out_valid !== 1'b1));
    check("words", n, act ? 384 : 0);
    check("active", active, act);
    check("refused", refused, rf);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    picture(PT_INTER, 1, 0, 0, 0, 16, 22'h00_0400, 22'h00_0400, 22'h00_0400, 1, 0, 0, 0);
    picture(PT_INTER, 1, 0, 0, 0, 12, 0, 0, 0, 0, 0, 0, 0);
    picture(PT_INTRA, 1, 0, 0, 0, 16, 0, 0, 0, 0, 0, 0, 0);
    picture(PT_INTER, 0, 0, 0, 0, 16, 0, 0, 0, 0, 0, 0, 0);
    picture(PT_B, 1, 1, 0, 0, 12, 22'h00_2000, 22'h00_3000, 22'h00_2000, 1, 0, 1, 0);
    picture(PT_IPB, 1, 0, 0, 0, 16, 22'h00_0800, 22'h00_0800, 22'h00_0800, 1, 0, 0, 0);
    picture(PT_EP, 1, 1, 0, 0, 12, 22'h00_0C00, 22'h00_0C00, 22'h00_0C00, 1, 0, 1, 0);
    picture(PT_INTER, 1, 0, 1, 1, 16, 22'h00_2000, 22'h00_3000, 22'h00_3000, 0, 0, 0, 0);
    picture(PT_INTER, 1, 1, 1, 0, 12, 0, 0, 0, 0, 1, 0, 0);
    picture(PT_INTER, 1, 1, 1, 1, 12, 22'h00_2000, 22'h00_3000, 22'h00_3000, 1, 0, 1, 1);
    stop_test;
  end
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule
